// ===== logic/nes_event_status.sv
`timescale 1ns/1ps
module nes_event_status
	import nes_pkg::*;
#(
	parameter int HUB_LIMIT_SLOW = HUB_WD_SLOW_CYC,
	parameter int HUB_LIMIT_FAST = HUB_WD_FAST_CYC,
	parameter int WATCH_CYCLES   = WATCH_PERIOD_CYC
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              reset_n_i,
	input  wire logic              soft_reset_i,
	// Host parallel bus
	input  wire nes_bus_req_t      bus_i,
	output logic      [DATA_W-1:0] bus_rdata_o,
	// Receive events
	input  wire nes_rx_err_t       rx_err_i,
	input  wire logic              decode_fix_i,
	input  wire logic [3:0]        decode_detail_i,
	input  wire logic              free_rx_done_i,
	input  wire logic              remote_rx_done_i,
	input  wire logic              rx_done_i,
	input  wire logic [ID_W-1:0]   rx_dest_id_i,
	input  wire logic [ID_W-1:0]   rx_source_id_i,
	input  wire logic [ID_W-1:0]   node_id_i,
	// Time synchronisation
	input  wire logic              standalone_i,
	input  wire logic              strap_master_i,
	input  wire logic              took_master_i,
	input  wire logic              master_id_set_i,
	input  wire logic              sync_locked_i,
	// Transmit events
	input  wire logic              token_retry_i,
	input  wire logic              reply_fix_i,
	input  wire logic              tx_done_i,
	input  wire logic [7:0]        tx_pointer_i,
	input  wire logic [7:0]        page_last_i,
	input  wire logic              fbe_no_reply_i,
	input  wire logic              tx_fail_i,
	input  wire logic              core_irq_i,
	input  wire logic              tx_avail_i,
	// Hub
	input  wire logic              hub_tx_active_i,
	input  wire logic              hub_on_i,
	input  wire logic              rate_fast_i,
	output logic                   hub_reset_o,
	output logic      [1:0]        line_reset_o,
	// Commands and interrupt
	output logic                   send_cmd_o,
	output logic                   page_flags_clr_o,
	output logic                   irq_o
);

	localparam int WCW = $clog2(WATCH_CYCLES + 1);

	// ========================================================================
	// Bus decode
	// ========================================================================
	logic        wr_status;
	logic        wr_mask;
	logic        wr_cmd;
	logic        wr_search;
	logic        cmd_send;
	logic        cmd_watch;

	always_comb begin
		wr_status = 1'b0;
		wr_mask   = 1'b0;
		wr_cmd    = 1'b0;
		wr_search = 1'b0;
		if (bus_i.wr && nes_hit(bus_i.addr, EVENT_STATUS_OFS)) begin
			wr_status = 1'b1;
		end else if (bus_i.wr && nes_hit(bus_i.addr, EVENT_MASK_OFS)) begin
			wr_mask = 1'b1;
		end else if (bus_i.wr && nes_hit(bus_i.addr, COMMAND_OFS)) begin
			wr_cmd = 1'b1;
		end else if (bus_i.wr && nes_hit(bus_i.addr, SEARCH_SOURCE_OFS)) begin
			wr_search = 1'b1;
		end
		cmd_send  = wr_cmd && (bus_i.wdata[7:0] == CMD_SEND);
		cmd_watch = wr_cmd && (bus_i.wdata[7:0] == CMD_WATCH_CLR);
	end

	// ========================================================================
	// Host registers
	// ========================================================================
	logic [DATA_W-1:0] mask;
	logic [DATA_W-1:0] next_mask;
	logic [7:0]        command;
	logic [7:0]        next_command;
	logic [ID_W-1:0]   search;
	logic [ID_W-1:0]   next_search;

	always_comb begin
		next_mask    = wr_mask ? bus_i.wdata : mask;
		next_command = wr_cmd ? bus_i.wdata[7:0] : command;
		next_search  = wr_search ? bus_i.wdata[ID_W-1:0] : search;
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			mask    <= MASK_RST;
			command <= COMMAND_RST;
			search  <= SEARCH_RST;
		end else begin
			mask    <= next_mask;
			command <= next_command;
			search  <= next_search;
		end
	end

	// ========================================================================
	// Watch timer
	// ========================================================================
	logic           watch_run;
	logic           next_watch_run;
	logic [WCW-1:0] watch_count;
	logic [WCW-1:0] next_watch_count;
	logic           watch_expire;

	// Restarts on the clear command and, while running, on every remote-buffer reception.
	always_comb begin
		next_watch_run   = watch_run;
		next_watch_count = watch_count;
		watch_expire     = 1'b0;
		if (soft_reset_i) begin
			next_watch_run   = 1'b0;
			next_watch_count = '0;
		end else if (cmd_watch) begin
			next_watch_run   = 1'b1;
			next_watch_count = '0;
		end else if (watch_run) begin
			if (remote_rx_done_i) begin
				next_watch_count = '0;
			end else if (watch_count == WCW'(WATCH_CYCLES - 1)) begin
				watch_expire     = 1'b1;
				next_watch_count = '0;
			end else begin
				next_watch_count = watch_count + WCW'(1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			watch_run   <= 1'b0;
			watch_count <= '0;
		end else begin
			watch_run   <= next_watch_run;
			watch_count <= next_watch_count;
		end
	end

	// ========================================================================
	// Hub watchdog
	// ========================================================================
	logic hub_timeout;

	nes_hub_watchdog #(
		.LIMIT_SLOW (HUB_LIMIT_SLOW),
		.LIMIT_FAST (HUB_LIMIT_FAST)
	) u_hub_watchdog (
		.clk_i           (clk_i),
		.reset_n_i       (reset_n_i),
		.hub_tx_active_i (hub_tx_active_i),
		.rate_fast_i     (rate_fast_i),
		.timeout_o       (hub_timeout)
	);

	// ========================================================================
	// Event flags
	// ========================================================================
	logic [DATA_W-1:0] set_vec;
	logic [DATA_W-1:0] clr_vec;
	logic [DATA_W-1:0] flags;
	logic              rx_err_set;
	logic              bad_ptr;

	always_comb begin
		rx_err_set = rx_err_i.abort && rx_err_i.data_frame;
		bad_ptr    = (tx_pointer_i <= 8'h02) || (tx_pointer_i > page_last_i);
		set_vec    = '0;
		set_vec[BIT_RX_ERR]     = rx_err_set;
		set_vec[BIT_DECODE_FIX] = decode_fix_i;
		set_vec[BIT_WATCH]      = watch_expire;
		set_vec[BIT_FREE_RX]    = free_rx_done_i;
		set_vec[BIT_REMOTE_RX]  = remote_rx_done_i;
		set_vec[BIT_OWN_RX]     = rx_done_i && (rx_dest_id_i == node_id_i);
		set_vec[BIT_SRC_MATCH]  = rx_done_i && (rx_source_id_i == search);
		set_vec[BIT_TOKEN_RTY]  = token_retry_i;
		set_vec[BIT_REPLY_FIX]  = reply_fix_i;
		set_vec[BIT_HUB_WD]     = hub_timeout;
		set_vec[BIT_BAD_PTR]    = tx_done_i && bad_ptr;
		set_vec[BIT_FBE_NOREP]  = fbe_no_reply_i;
		set_vec[BIT_TX_ERR]     = tx_fail_i || fbe_no_reply_i;
		clr_vec = wr_status ? (bus_i.wdata & W1C_MASK) : '0;
		if (soft_reset_i || cmd_watch) begin
			clr_vec = FLAG_MASK;
		end
		if (cmd_send) begin
			clr_vec[BIT_FBE_NOREP] = 1'b1;
			clr_vec[BIT_TX_ERR]    = 1'b1;
		end
	end

	nes_flag_bank #(
		.W    (DATA_W),
		.MASK (FLAG_MASK)
	) u_flag_bank (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.set_i     (set_vec),
		.clr_i     (clr_vec),
		.flags_o   (flags)
	);

	// ========================================================================
	// Error information capture
	// ========================================================================
	logic [DATA_W-1:0] err_info;
	logic [DATA_W-1:0] next_err_info;

	always_comb begin
		next_err_info = err_info;
		if (rx_err_set) begin
			next_err_info[RX_CODE_LSB +: 3]   = rx_err_i.code;
			next_err_info[SENDER_LSB +: ID_W] = rx_err_i.sender;
		end
		if (decode_fix_i) begin
			next_err_info[DECODE_LSB +: 4] = decode_detail_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			err_info <= ERROR_INFO_RST;
		end else begin
			err_info <= next_err_info;
		end
	end

	// ========================================================================
	// Time synchronisation unlock
	// ========================================================================
	logic unlocked;
	logic next_unlocked;

	always_comb begin
		next_unlocked = unlocked;
		if (soft_reset_i) begin
			next_unlocked = 1'b1;
		end else if (standalone_i && strap_master_i) begin
			next_unlocked = 1'b0;
		end else if (took_master_i || master_id_set_i || sync_locked_i) begin
			next_unlocked = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			unlocked <= UNLOCKED_RST;
		end else begin
			unlocked <= next_unlocked;
		end
	end

	// ========================================================================
	// Status word, read data, outputs
	// ========================================================================
	logic [DATA_W-1:0] status;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] next_rdata;
	logic              hub_rst;
	logic              next_hub_rst;
	logic [1:0]        line_rst;
	logic [1:0]        next_line_rst;

	always_comb begin
		status = flags;
		status[BIT_UNLOCKED] = unlocked;
		status[BIT_CORE]     = core_irq_i;
		status[BIT_TX_AVAIL] = tx_avail_i;
		next_rdata = '0;
		if (bus_i.rd && nes_hit(bus_i.addr, EVENT_STATUS_OFS)) begin
			next_rdata = status;
		end else if (bus_i.rd && nes_hit(bus_i.addr, EVENT_MASK_OFS)) begin
			next_rdata = mask;
		end else if (bus_i.rd && nes_hit(bus_i.addr, COMMAND_OFS)) begin
			next_rdata = {8'h00, command};
		end else if (bus_i.rd && nes_hit(bus_i.addr, SEARCH_SOURCE_OFS)) begin
			next_rdata = {11'h000, search};
		end else if (bus_i.rd && nes_hit(bus_i.addr, ERROR_INFO_OFS)) begin
			next_rdata = err_info;
		end
		next_hub_rst  = hub_timeout;
		next_line_rst = {2{hub_timeout && hub_on_i}};
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rdata    <= '0;
			hub_rst  <= 1'b0;
			line_rst <= 2'b00;
		end else begin
			rdata    <= next_rdata;
			hub_rst  <= next_hub_rst;
			line_rst <= next_line_rst;
		end
	end

	assign bus_rdata_o      = rdata;
	assign hub_reset_o      = hub_rst;
	assign line_reset_o     = line_rst;
	assign send_cmd_o       = cmd_send;
	assign page_flags_clr_o = cmd_watch;
	assign irq_o            = |(status & mask);

	// ========================================================================
	// Checks
	// ========================================================================
	property p_rx_err_capture;
		@(posedge clk_i) disable iff (!reset_n_i)
		(rx_err_i.abort && rx_err_i.data_frame) |=> flags[BIT_RX_ERR] && (err_info[7:5] == $past(rx_err_i.code))
			&& (err_info[4:0] == $past(rx_err_i.sender));
	endproperty
	a_rx_err_capture: assert property (p_rx_err_capture) else $error("Receive error not captured.");

	property p_rx_err_cause;
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(flags[BIT_RX_ERR]) |-> $past(rx_err_i.abort) && $past(rx_err_i.data_frame);
	endproperty
	a_rx_err_cause: assert property (p_rx_err_cause) else $error("Receive error set by a non-data frame.");

	property p_w1c;
		@(posedge clk_i) disable iff (!reset_n_i)
		(wr_status && bus_i.wdata[BIT_SRC_MATCH] && !set_vec[BIT_SRC_MATCH]) |=> !flags[BIT_SRC_MATCH];
	endproperty
	a_w1c: assert property (p_w1c) else $error("Written one left a flag set.");

	property p_watch_hold;
		@(posedge clk_i) disable iff (!reset_n_i)
		(flags[BIT_WATCH] && !soft_reset_i && !cmd_watch) |=> flags[BIT_WATCH];
	endproperty
	a_watch_hold: assert property (p_watch_hold) else $error("Watch flag cleared without command.");

	property p_soft_unlock;
		@(posedge clk_i) disable iff (!reset_n_i)
		soft_reset_i |=> unlocked ##1 (unlocked
			|| $past(took_master_i || master_id_set_i || sync_locked_i || (standalone_i && strap_master_i)));
	endproperty
	a_soft_unlock: assert property (p_soft_unlock) else $error("Soft reset did not mark sync unlocked.");

	property p_send_clears;
		@(posedge clk_i) disable iff (!reset_n_i)
		(cmd_send && !tx_fail_i && !fbe_no_reply_i) |=> !flags[BIT_TX_ERR] && !flags[BIT_FBE_NOREP];
	endproperty
	a_send_clears: assert property (p_send_clears) else $error("Send command left transmit errors set.");

	property p_fbe_both;
		@(posedge clk_i) disable iff (!reset_n_i)
		fbe_no_reply_i |=> flags[BIT_FBE_NOREP] && flags[BIT_TX_ERR];
	endproperty
	a_fbe_both: assert property (p_fbe_both) else $error("Enquiry no-reply did not set both flags.");

	property p_hub_line;
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(flags[BIT_HUB_WD]) |-> hub_rst && (line_rst == {2{$past(hub_on_i)}});
	endproperty
	a_hub_line: assert property (p_hub_line) else $error("Hub timeout reset outputs wrong.");

	property p_irq_mask;
		@(posedge clk_i) disable iff (!reset_n_i)
		(wr_mask && (bus_i.wdata == '0)) |=> !irq_o;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("Interrupt raised with all events masked.");

endmodule // nes_event_status

// ===== logic/nes_flag_bank.sv
`timescale 1ns/1ps
module nes_flag_bank
	import nes_pkg::*;
#(
	parameter int          W    = 16,
	parameter logic [15:0] MASK = FLAG_MASK
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         reset_n_i,
	// Set and clear requests
	input  wire logic [W-1:0] set_i,
	input  wire logic [W-1:0] clr_i,
	// Flags
	output logic      [W-1:0] flags_o
);

	logic [W-1:0] flags;
	logic [W-1:0] next_flags;

	// A set in the same cycle as a clear wins, so no event is lost.
	always_comb begin
		next_flags = ((flags & ~clr_i) | set_i) & MASK[W-1:0];
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			flags <= FLAGS_RST[W-1:0];
		end else begin
			flags <= next_flags;
		end
	end

	assign flags_o = flags;

	property p_set_wins;
		@(posedge clk_i) disable iff (!reset_n_i)
		(|(set_i & clr_i & MASK[W-1:0])) |=> ((flags & $past(set_i & clr_i & MASK[W-1:0])) != '0);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("Flag lost to a same-cycle clear.");

endmodule // nes_flag_bank

// ===== logic/nes_hub_watchdog.sv
`timescale 1ns/1ps
module nes_hub_watchdog
	import nes_pkg::*;
#(
	parameter int LIMIT_SLOW = HUB_WD_SLOW_CYC,
	parameter int LIMIT_FAST = HUB_WD_FAST_CYC
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	// Hub state
	input  wire logic hub_tx_active_i,
	input  wire logic rate_fast_i,
	// Result
	output logic      timeout_o
);

	localparam int CW = $clog2(LIMIT_SLOW + 1);

	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic          timeout;
	logic          next_timeout;
	logic [CW-1:0] limit;

	// Counts continuous hub transmit activity and saturates at the limit.
	always_comb begin
		limit        = rate_fast_i ? CW'(LIMIT_FAST) : CW'(LIMIT_SLOW);
		next_count   = count;
		next_timeout = 1'b0;
		if (!hub_tx_active_i) begin
			next_count = '0;
		end else if (count < limit) begin
			next_count = count + CW'(1);
			next_timeout = (count == limit - CW'(1));
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			count   <= '0;
			timeout <= 1'b0;
		end else begin
			count   <= next_count;
			timeout <= next_timeout;
		end
	end

	assign timeout_o = timeout;

	property p_timeout_cause;
		@(posedge clk_i) disable iff (!reset_n_i)
		timeout |-> ($past(count) == $past(limit) - CW'(1)) && $past(hub_tx_active_i);
	endproperty
	a_timeout_cause: assert property (p_timeout_cause) else $error("Hub timeout without full active period.");

endmodule // nes_hub_watchdog

// ===== logic/nes_pkg.sv
package nes_pkg;

	// ========================================================================
	// Register map and widths
	// ========================================================================
	localparam int         DATA_W            = 16;
	localparam int         ADDR_W            = 8;
	localparam int         ID_W              = 5;
	localparam logic [7:0] EVENT_STATUS_OFS  = 8'h12;
	localparam logic [7:0] EVENT_MASK_OFS    = 8'h14;
	localparam logic [7:0] COMMAND_OFS       = 8'h16;
	localparam logic [7:0] SEARCH_SOURCE_OFS = 8'h1a;
	localparam logic [7:0] ERROR_INFO_OFS    = 8'h20;

	// ========================================================================
	// Event status bit positions
	// ========================================================================
	localparam int BIT_RX_ERR     = 15;
	localparam int BIT_DECODE_FIX = 14;
	localparam int BIT_UNLOCKED   = 13;
	localparam int BIT_WATCH      = 12;
	localparam int BIT_FREE_RX    = 11;
	localparam int BIT_REMOTE_RX  = 10;
	localparam int BIT_OWN_RX     = 9;
	localparam int BIT_SRC_MATCH  = 8;
	localparam int BIT_TOKEN_RTY  = 7;
	localparam int BIT_REPLY_FIX  = 6;
	localparam int BIT_HUB_WD     = 5;
	localparam int BIT_BAD_PTR    = 4;
	localparam int BIT_CORE       = 3;
	localparam int BIT_FBE_NOREP  = 2;
	localparam int BIT_TX_ERR     = 1;
	localparam int BIT_TX_AVAIL   = 0;

	// Bits that a written 1 clears, and bits held in the sticky flag bank.
	localparam logic [15:0] W1C_MASK  = 16'hcff6;
	localparam logic [15:0] FLAG_MASK = 16'hdff6;

	// ========================================================================
	// Error information fields
	// ========================================================================
	localparam int RX_CODE_LSB   = 5;
	localparam int SENDER_LSB    = 0;
	localparam int DECODE_LSB    = 8;

	// ========================================================================
	// Reset values and commands
	// ========================================================================
	localparam logic [15:0] FLAGS_RST      = 16'h0000;
	localparam logic [15:0] MASK_RST       = 16'h0000;
	localparam logic [15:0] ERROR_INFO_RST = 16'h0000;
	localparam logic [4:0]  SEARCH_RST     = 5'h00;
	localparam logic [7:0]  COMMAND_RST    = 8'h00;
	localparam logic        UNLOCKED_RST   = 1'b1;
	localparam logic [7:0]  CMD_SEND       = 8'h03;
	localparam logic [7:0]  CMD_WATCH_CLR  = 8'h0a;

	// ========================================================================
	// Timing
	// ========================================================================
	localparam int CLK_MHZ           = 50;
	localparam int HUB_WD_SLOW_US100 = 327;
	localparam int HUB_WD_FAST_US100 = 164;
	localparam int HUB_WD_SLOW_CYC   = HUB_WD_SLOW_US100 * CLK_MHZ * 10;
	localparam int HUB_WD_FAST_CYC   = HUB_WD_FAST_US100 * CLK_MHZ * 10;
	localparam int WATCH_PERIOD_MS   = 100;
	localparam int WATCH_PERIOD_CYC  = WATCH_PERIOD_MS * CLK_MHZ * 1000;

	// ========================================================================
	// Carriers
	// ========================================================================
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} nes_bus_req_t;

	typedef struct packed {
		logic            abort;
		logic            data_frame;
		logic [2:0]      code;
		logic [ID_W-1:0] sender;
	} nes_rx_err_t;

	function automatic logic nes_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
		nes_hit = (addr[ADDR_W-1:1] == ofs[ADDR_W-1:1]);
	endfunction

endpackage

// ===== verification/nes_event_status_tb_top.sv
`timescale 1ns/1ps
module nes_event_status_tb_top;
	import nes_pkg::*;
	logic         clk_i = 0, reset_n_i = 0, soft_reset_i = 0, df = 1, hub_tx_active_i = 0, fast = 0;
	logic         hub_on = 1, alone = 0, strap = 0;
	logic [15:0]  ev = '0, rdata, exp;
	logic [4:0]   node, srch, snd;
	logic [2:0]   code;
	logic [3:0]   det;
	logic [7:0]   plast, ptr;
	logic [1:0]   line_reset_o;
	logic         irq_o, hub_reset_o, send_cmd_o, page_clr;
	nes_bus_req_t bus;
	int           mismatches = 0, comparisons = 0, n_hub = 0, n_line = 0, n_send = 0, n_clr = 0;
	int           bits[11] = '{15, 14, 11, 10, 9, 8, 7, 6, 4, 2, 1};
	logic [15:0]  q[$];

	nes_host_model nes_host_model_i (.clk_i(clk_i), .bus_o(bus));
	nes_event_status #(.HUB_LIMIT_SLOW(20), .HUB_LIMIT_FAST(10), .WATCH_CYCLES(50)) nes_event_status_i (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .soft_reset_i(soft_reset_i), .bus_i(bus), .bus_rdata_o(rdata),
		.rx_err_i(nes_rx_err_t'{ev[15], df, code, snd}), .decode_fix_i(ev[14]), .decode_detail_i(det),
		.free_rx_done_i(ev[11]), .remote_rx_done_i(ev[10]), .rx_done_i(ev[9] | ev[8]),
		.rx_dest_id_i(ev[9] ? node : ~node), .rx_source_id_i(ev[8] ? srch : ~srch), .node_id_i(node),
		.standalone_i(alone), .strap_master_i(strap), .took_master_i(ev[5]), .master_id_set_i(ev[12]),
		.sync_locked_i(ev[13]), .token_retry_i(ev[7]), .reply_fix_i(ev[6]), .tx_done_i(ev[4]),
		.tx_pointer_i(ptr), .page_last_i(plast), .fbe_no_reply_i(ev[2]), .tx_fail_i(ev[1]),
		.core_irq_i(ev[3]), .tx_avail_i(ev[0]), .hub_tx_active_i(hub_tx_active_i), .hub_on_i(hub_on),
		.rate_fast_i(fast), .hub_reset_o(hub_reset_o), .line_reset_o(line_reset_o), .send_cmd_o(send_cmd_o),
		.page_flags_clr_o(page_clr), .irq_o(irq_o));

	initial forever #10 clk_i = ~clk_i;

	// ========================================================================
	// Checking
	// ========================================================================
	task check(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	// Read data stands in the cycle after the edge that took the read.
	always @(negedge clk_i) if (bus.rd === 1'b1) check("rdata", q.pop_front(), rdata);

	always @(posedge clk_i) begin
		n_hub += hub_reset_o;
		n_line += (line_reset_o === 2'b11);
		n_send += send_cmd_o;
		n_clr += page_clr;
	end

	task results;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ========================================================================
	// Stimulus
	// ========================================================================
	task rd(input logic [7:0] a, input logic [15:0] e);
		q.push_back(e);
		nes_host_model_i.rd(a);
	endtask

	task pulse(input int k);
		@(negedge clk_i) ev[k] = 1'b1;
		@(negedge clk_i) ev[k] = 1'b0;
	endtask

	task hold(input int n);
		@(negedge clk_i) hub_tx_active_i = 1'b1;
		repeat (n) @(negedge clk_i);
		hub_tx_active_i = 1'b0;
	endtask

	initial begin
		#50us;
		mismatches++;
		results;
	end

	initial begin
		void'($urandom(4177));
		{node, srch, snd, code, det} = 22'($urandom);
		plast = 8'h03 + 8'($urandom % 200);
		ptr = 8'($urandom % 3);
		repeat (20) @(posedge clk_i);
		@(negedge clk_i) reset_n_i = 1'b1;
		rd(EVENT_STATUS_OFS, 16'h2000);
		rd(EVENT_MASK_OFS, 16'h0000);
		nes_host_model_i.wr(SEARCH_SOURCE_OFS, {11'h000, srch});
		df = 1'b0;
		pulse(15);
		df = 1'b1;
		rd(EVENT_STATUS_OFS, 16'h2000);
		foreach (bits[i]) begin
			exp = (16'h0001 << bits[i]) | (bits[i] == 2 ? 16'h0002 : 16'h0000);
			pulse(bits[i]);
			rd(EVENT_STATUS_OFS, 16'h2000 | exp);
			nes_host_model_i.wr(EVENT_STATUS_OFS, exp);
			rd(EVENT_STATUS_OFS, 16'h2000);
		end
		ptr = plast;
		pulse(4);
		rd(EVENT_STATUS_OFS, 16'h2000);
		ptr = plast + 8'h01;
		pulse(4);
		rd(EVENT_STATUS_OFS, 16'h2010);
		nes_host_model_i.wr(EVENT_STATUS_OFS, 16'h0010);
		rd(ERROR_INFO_OFS, {4'h0, det, code, snd});
		ev[3] = 1'b1;
		ev[0] = 1'b1;
		nes_host_model_i.wr(EVENT_STATUS_OFS, 16'h3009);
		rd(EVENT_STATUS_OFS, 16'h2009);
		ev[3] = 1'b0;
		ev[0] = 1'b0;
		hold(19);
		rd(EVENT_STATUS_OFS, 16'h2000);
		hold(25);
		rd(EVENT_STATUS_OFS, 16'h2020);
		nes_host_model_i.wr(EVENT_STATUS_OFS, 16'h0020);
		fast = 1'b1;
		hold(12);
		rd(EVENT_STATUS_OFS, 16'h2020);
		hub_on = 1'b0;
		hold(12);
		rd(EVENT_STATUS_OFS, 16'h2020);
		check("hub resets", 16'h0302, {n_hub[7:0], n_line[7:0]});
		nes_host_model_i.wr(EVENT_MASK_OFS, 16'h2000);
		check("irq", 16'h0001, {15'h0, irq_o});
		nes_host_model_i.wr(EVENT_MASK_OFS, 16'h0080);
		check("irq", 16'h0000, {15'h0, irq_o});
		fork
			nes_host_model_i.wr(EVENT_STATUS_OFS, 16'h0080);
			pulse(7);
		join
		check("irq", 16'h0001, {15'h0, irq_o});
		rd(EVENT_STATUS_OFS, 16'h20a0);
		nes_host_model_i.wr(EVENT_MASK_OFS, 16'h0000);
		check("irq", 16'h0000, {15'h0, irq_o});
		pulse(13);
		rd(EVENT_STATUS_OFS, 16'h00a0);
		@(negedge clk_i) soft_reset_i = 1'b1;
		@(negedge clk_i) soft_reset_i = 1'b0;
		rd(EVENT_STATUS_OFS, 16'h2000);
		pulse(1);
		nes_host_model_i.wr(COMMAND_OFS, {8'h00, CMD_SEND});
		rd(EVENT_STATUS_OFS, 16'h2000);
		pulse(7);
		nes_host_model_i.wr(COMMAND_OFS, {8'h00, CMD_WATCH_CLR});
		rd(EVENT_STATUS_OFS, 16'h2000);
		repeat (60) @(negedge clk_i);
		nes_host_model_i.wr(EVENT_STATUS_OFS, 16'h1000);
		rd(EVENT_STATUS_OFS, 16'h3000);
		nes_host_model_i.wr(COMMAND_OFS, {8'h00, CMD_WATCH_CLR});
		rd(EVENT_STATUS_OFS, 16'h2000);
		check("command pulses", 16'h0102, {n_send[7:0], n_clr[7:0]});
		@(negedge clk_i) reset_n_i = 1'b0;
		alone = 1'b1;
		strap = 1'b1;
		repeat (2) @(negedge clk_i);
		reset_n_i = 1'b1;
		rd(EVENT_STATUS_OFS, 16'h0000);
		results;
	end
endmodule // nes_event_status_tb_top

// ===== verification/nes_host_model.sv
`timescale 1ns/1ps
module nes_host_model
	import nes_pkg::*;
(
	// Clock
	input  wire logic   clk_i,
	// Parallel bus towards the block
	output nes_bus_req_t bus_o
);
	initial bus_o = '0;

	// ========================================================================
	// Bus cycles
	// ========================================================================
	// An idle bus shows the inverse of the last address and data, so stale values never pass.
	task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(negedge clk_i) bus_o <= '{w, !w, a, d};
		@(negedge clk_i) bus_o <= '{1'b0, 1'b0, ~a, ~d};
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		access(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		access(1'b0, a, 16'h0000);
	endtask
endmodule // nes_host_model
